// File: rtl/iam_pkg.sv
/*
 * Shared constants for the two-wire address-match and status-flag block:
 * register offsets, field positions, reset values and link states.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
`default_nettype none

package iam_pkg;

	// ------------------------------------------------------------------
	// Register map (byte offsets on the AXI4-Lite bus)
	// ------------------------------------------------------------------
	localparam int unsigned IAM_AXI_AW      = 8;
	localparam logic [7:0]  IAM_OFF_STATUS  = 8'h00;
	localparam logic [7:0]  IAM_OFF_SLVADR  = 8'h04;
	localparam logic [7:0]  IAM_OFF_RXDATA  = 8'h08;
	localparam logic [7:0]  IAM_OFF_IRQSTAT = 8'h0c;
	localparam logic [7:0]  IAM_OFF_IRQMASK = 8'h10;

	// ------------------------------------------------------------------
	// Flag vector indices, shared by status, irq status and irq mask
	// ------------------------------------------------------------------
	localparam int unsigned IAM_F_GC  = 0;
	localparam int unsigned IAM_F_AAS = 1;
	localparam int unsigned IAM_F_AL  = 2;
	localparam int unsigned IAM_F_RXF = 3;
	localparam int unsigned IAM_NFLAG = 4;

	// ------------------------------------------------------------------
	// Bit positions inside the status register byte
	// ------------------------------------------------------------------
	localparam int unsigned IAM_SB_GC  = 0;
	localparam int unsigned IAM_SB_AAS = 1;
	localparam int unsigned IAM_SB_AL  = 2;
	localparam int unsigned IAM_SB_RXF = 5;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] IAM_SLVADR_RST = 8'h00;
	localparam logic [7:0] IAM_RXDATA_RST = 8'hff;
	localparam logic [3:0] IAM_FLAG_RST   = 4'h0;
	localparam logic [3:0] IAM_MASK_RST   = 4'h0;

	// ------------------------------------------------------------------
	// Frame counting: index of the last data bit and of the acknowledge
	// ------------------------------------------------------------------
	localparam logic [3:0] IAM_LAST_BIT = 4'h7;
	localparam logic [3:0] IAM_ACK_BIT  = 4'h8;

	// ------------------------------------------------------------------
	// Bus responses
	// ------------------------------------------------------------------
	localparam logic [1:0] IAM_RESP_OKAY   = 2'h0;
	localparam logic [1:0] IAM_RESP_SLVERR = 2'h2;

	// Position on the two-wire link relative to start and stop.
	typedef enum logic [1:0] {
		LNK_IDLE,
		LNK_FIRST,
		LNK_DATA
	} iam_link_e;

endpackage

`default_nettype wire

// File: rtl/iam_sync.sv
/*
 * Two-flop synchroniser for pin inputs of the two-wire link.
 * Assumes inputs are asynchronous to clk_sys_i; only the second stage
 * may be read by other logic.
 */
`timescale 1ns/10ps
`default_nettype none

module iam_sync #(
	parameter int unsigned WIDTH = 2
) (
	// Clock, reset, enable
	input  wire logic             clk_sys_i,
	input  wire logic             resetn_i,
	input  wire logic             clk_en_i,
	// Data
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] stage1;

	// The idle bus is high, so both stages reset high.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stage1 <= '1;
			q_o    <= '1;
		end else if (clk_en_i) begin
			stage1 <= d_i;
			q_o    <= stage1;
		end
	end

endmodule // iam_sync

`default_nettype wire

// File: rtl/iam_status_flags.sv
/*
 * Status flags and own-address recognition of a two-wire serial
 * controller, with an AXI4-Lite register slave and a level interrupt.
 * Assumes the rest of the unit supplies mode bits and the internal SDA
 * drive level on clk_sys_i; SCL and SDA pins are asynchronous.
 */
// Functional notes
// - In master transmit, a mismatch of driven and sampled SDA at SCL rise sets the arbitration-lost flag.
// - In master mode, a start seen while our SDA drive is high sets the arbitration-lost flag.
// - In synchronous format, a final bit arriving while receive-full is 1 sets the same flag as overrun.
// - Status bit 2 means arbitration lost or overrun by format and resets to 0.
// - The arbitration-lost flag clears only by writing 0 after it was read as 1.
// - In slave receive, a first frame equal to the own address sets the address-match flag, bit 1.
// - In slave receive, a general call first frame also sets the address-match flag.
// - The address-match flag clears only by writing 0 after it was read as 1.
// - The general call flag, bit 0, is set only in two-wire slave receive on a general call.
// - The general call flag clears only by writing 0 after it was read as 1.
// - In two-wire slave mode the device is addressed when frame bits 7..1 equal the own address.
// - The own address sits in bits 7..1 of the address register and resets to zero.
// - Bit 0 of the address register selects two-wire (0) or synchronous (1) format, reset 0.
// - Moving a received byte into the receive data register sets the receive-full flag.
`timescale 1ns/10ps
`default_nettype none

module iam_status_flags
	import iam_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                  clk_sys_i,
	input  wire logic                  resetn_i,
	input  wire logic                  clk_en_i,
	// AXI4-Lite write address and data
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [IAM_AXI_AW-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	// AXI4-Lite write response
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	output logic      [1:0]            s_axi_bresp,
	// AXI4-Lite read
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	input  wire logic [IAM_AXI_AW-1:0] s_axi_araddr,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output logic      [31:0]           s_axi_rdata,
	output logic      [1:0]            s_axi_rresp,
	// Two-wire pins, asynchronous
	input  wire logic                  scl_i,
	input  wire logic                  sda_i,
	// Rest of the unit, same clock
	input  wire logic                  master_mode_i,
	input  wire logic                  transmit_mode_i,
	input  wire logic                  sda_drive_i,
	// Results
	output logic                       addressed_o,
	output logic                       rx_full_flag_o,
	output logic      [7:0]            rx_data_o,
	output logic                       irq_o
);

	// ------------------------------------------------------------------
	// Address decode helper
	// ------------------------------------------------------------------
	function automatic logic hit(input logic [IAM_AXI_AW-1:0] a,
		input logic [7:0] off);
		hit = (a[IAM_AXI_AW-1:2] == off[IAM_AXI_AW-1:2]);
	endfunction

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic                  aw_held, w_held;
	logic [IAM_AXI_AW-1:0] aw_addr_q;
	logic [7:0]            w_byte_q;
	logic                  w_lane0_q;
	logic [7:0]            slave_address_reg;
	logic [IAM_NFLAG-1:0]  flg_q, arm_q, irq_stat_q, irq_mask_q;
	logic [IAM_NFLAG-1:0]  set_vec, clr_vec, next_flg;
	logic [7:0]            bus_status_reg, shift_reg, rx_byte;
	logic [3:0]            bit_cnt;
	logic [1:0]            pins_s;
	logic                  scl_s, sda_s, scl_d, sda_d;
	logic                  addressed_q;
	iam_link_e             link_st;

	// ------------------------------------------------------------------
	// Pin synchronisation and bus condition detection
	// ------------------------------------------------------------------
	iam_sync #(
		.WIDTH (2)
	) u_sync (
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.clk_en_i  (clk_en_i),
		.d_i       ({scl_i, sda_i}),
		.q_o       (pins_s)
	);

	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	// Previous synchronised levels, for edge finding.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else if (clk_en_i) begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	// Start and stop need SCL high on both samples around the SDA edge.
	wire scl_rise  = scl_s & ~scl_d;
	wire scl_high  = scl_s & scl_d;
	wire start_det = scl_high & sda_d & ~sda_s;
	wire stop_det  = scl_high & ~sda_d & sda_s;

	// ------------------------------------------------------------------
	// Format and mode decode
	// ------------------------------------------------------------------
	// own address field
	wire [6:0] own_slave_address = slave_address_reg[7:1];
	wire       format_select     = slave_address_reg[0];
	wire       slave_rx  = ~master_mode_i & ~transmit_mode_i & ~format_select;
	wire [3:0] frame_end = format_select ? IAM_LAST_BIT : IAM_ACK_BIT;
	wire       byte_done = scl_rise & (bit_cnt == IAM_LAST_BIT);
	wire       is_first  = (link_st == LNK_FIRST);

	assign rx_byte = {shift_reg[6:0], sda_s};

	// ------------------------------------------------------------------
	// Bit counter, shift register and link position
	// ------------------------------------------------------------------
	// Each SCL rise moves one bit; the acknowledge slot shifts nothing.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bit_cnt   <= 4'h0;
			shift_reg <= 8'h00;
		end else if (clk_en_i) begin
			if (start_det && !format_select) begin
				bit_cnt <= 4'h0;
			end else if (scl_rise) begin
				bit_cnt <= (bit_cnt == frame_end) ? 4'h0 : bit_cnt + 4'h1;
				if (bit_cnt <= IAM_LAST_BIT) begin
					shift_reg <= rx_byte;
				end
			end
		end
	end

	// Tracks whether the next byte is the first frame after a start.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			link_st <= LNK_IDLE;
		end else if (clk_en_i) begin
			case (link_st)
				LNK_IDLE:  link_st <= start_det ? LNK_FIRST : LNK_IDLE;
				LNK_FIRST: begin
					if (stop_det) begin
						link_st <= LNK_IDLE;
					end else if (byte_done) begin
						link_st <= LNK_DATA;
					end
				end
				LNK_DATA: begin
					if (stop_det) begin
						link_st <= LNK_IDLE;
					end else if (start_det) begin
						link_st <= LNK_FIRST;
					end
				end
				default:   link_st <= LNK_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Flag events
	// ------------------------------------------------------------------
	// general call is all-zero
	wire gc_addr  = (rx_byte[7:1] == 7'h00);
	wire gc_hit   = byte_done & is_first & slave_rx & gc_addr;
	wire own_hit  = byte_done & is_first & slave_rx &
		(rx_byte[7:1] == own_slave_address);
	wire al_arb   = ~format_select & master_mode_i & transmit_mode_i &
		scl_rise & (sda_drive_i != sda_s);
	wire al_start = ~format_select & master_mode_i & start_det &
		sda_drive_i;
	wire ovr      = format_select & byte_done & flg_q[IAM_F_RXF];
	// An overrun keeps the unread byte rather than losing it silently.
	wire rx_take  = byte_done & ~transmit_mode_i & ~ovr &
		(format_select | master_mode_i | addressed_q | own_hit | gc_hit);

	assign set_vec[IAM_F_AL]  = al_arb | al_start | ovr;
	assign set_vec[IAM_F_AAS] = own_hit | gc_hit;
	assign set_vec[IAM_F_GC]  = gc_hit;
	assign set_vec[IAM_F_RXF] = rx_take;

	// Slave selection holds from the match until the next start or stop.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			addressed_q <= 1'b0;
		end else if (clk_en_i) begin
			addressed_q <= (addressed_q & ~start_det & ~stop_det) |
				own_hit | gc_hit;
		end
	end

	// Received byte lands in the receive data register.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_data_o <= IAM_RXDATA_RST;
		end else if (clk_en_i && rx_take) begin
			rx_data_o <= rx_byte;
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite slave: write address and data are latched independently
	// ------------------------------------------------------------------
	assign s_axi_awready = ~aw_held & clk_en_i;
	assign s_axi_wready  = ~w_held & clk_en_i;
	assign s_axi_arready = ~s_axi_rvalid & clk_en_i;

	wire wr_go     = aw_held & w_held & ~s_axi_bvalid & clk_en_i;
	wire wr_en     = wr_go & w_lane0_q;
	wire rd_go     = s_axi_arvalid & s_axi_arready;
	wire wr_stat   = wr_en & hit(aw_addr_q, IAM_OFF_STATUS);
	wire rd_stat   = rd_go & hit(s_axi_araddr, IAM_OFF_STATUS);
	wire rd_rxd    = rd_go & hit(s_axi_araddr, IAM_OFF_RXDATA);
	wire rd_irq    = rd_go & hit(s_axi_araddr, IAM_OFF_IRQSTAT);
	wire wr_mapped = hit(aw_addr_q, IAM_OFF_STATUS) |
		hit(aw_addr_q, IAM_OFF_SLVADR) | hit(aw_addr_q, IAM_OFF_RXDATA) |
		hit(aw_addr_q, IAM_OFF_IRQSTAT) | hit(aw_addr_q, IAM_OFF_IRQMASK);
	wire [3:0] w_flags = {w_byte_q[IAM_SB_RXF], w_byte_q[IAM_SB_AL],
		w_byte_q[IAM_SB_AAS], w_byte_q[IAM_SB_GC]};

	// Write channel holding registers.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			aw_addr_q <= '0;
			w_byte_q  <= 8'h00;
			w_lane0_q <= 1'b0;
		end else if (clk_en_i) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held   <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held    <= 1'b1;
				w_byte_q  <= s_axi_wdata[7:0];
				w_lane0_q <= s_axi_wstrb[0];
			end else if (wr_go) begin
				w_held <= 1'b0;
			end
		end
	end

	// Write response; unmapped offsets answer SLVERR.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= IAM_RESP_OKAY;
		end else if (clk_en_i) begin
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped ? IAM_RESP_OKAY : IAM_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read mux; bits owned by the rest of the unit read as zero here.
	assign bus_status_reg = {2'b00, flg_q[IAM_F_RXF], 2'b00,
		flg_q[IAM_F_AL], flg_q[IAM_F_AAS], flg_q[IAM_F_GC]};
	wire [7:0] rd_byte =
		hit(s_axi_araddr, IAM_OFF_STATUS)  ? bus_status_reg :
		hit(s_axi_araddr, IAM_OFF_SLVADR)  ? slave_address_reg :
		hit(s_axi_araddr, IAM_OFF_RXDATA)  ? rx_data_o :
		hit(s_axi_araddr, IAM_OFF_IRQSTAT) ? {4'h0, irq_stat_q} :
		hit(s_axi_araddr, IAM_OFF_IRQMASK) ? {4'h0, irq_mask_q} : 8'h00;
	wire rd_mapped = hit(s_axi_araddr, IAM_OFF_STATUS) |
		hit(s_axi_araddr, IAM_OFF_SLVADR) |
		hit(s_axi_araddr, IAM_OFF_RXDATA) |
		hit(s_axi_araddr, IAM_OFF_IRQSTAT) |
		hit(s_axi_araddr, IAM_OFF_IRQMASK);

	// Read data channel.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= IAM_RESP_OKAY;
		end else if (clk_en_i) begin
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {24'h00_0000, rd_byte};
				s_axi_rresp  <= rd_mapped ? IAM_RESP_OKAY : IAM_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Flags, address register, interrupt
	// ------------------------------------------------------------------
	// read-1 then write-0 clear
	assign clr_vec = (arm_q & ~w_flags & {IAM_NFLAG{wr_stat}}) |
		({IAM_NFLAG{rd_rxd}} & (4'h1 << IAM_F_RXF));
	// A new event in the clearing cycle wins over the clear.
	assign next_flg = (flg_q & ~clr_vec) | set_vec;

	// Flags and their arming by status reads.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flg_q <= IAM_FLAG_RST;
			arm_q <= IAM_FLAG_RST;
		end else if (clk_en_i) begin
			flg_q <= next_flg;
			arm_q <= wr_stat ? 4'h0 : (rd_stat ? (arm_q | flg_q) : arm_q);
		end
	end

	// Address register, interrupt status and mask.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			slave_address_reg <= IAM_SLVADR_RST;
			irq_mask_q        <= IAM_MASK_RST;
			irq_stat_q        <= IAM_FLAG_RST;
		end else if (clk_en_i) begin
			if (wr_en && hit(aw_addr_q, IAM_OFF_SLVADR)) begin
				slave_address_reg <= w_byte_q;
			end
			if (wr_en && hit(aw_addr_q, IAM_OFF_IRQMASK)) begin
				irq_mask_q <= w_byte_q[3:0];
			end
			irq_stat_q <= (rd_irq ? 4'h0 : irq_stat_q) | set_vec;
		end
	end

	assign irq_o          = |(irq_stat_q & irq_mask_q);
	assign addressed_o    = addressed_q;
	assign rx_full_flag_o = flg_q[IAM_F_RXF];

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	property p_arb_mismatch;
		al_arb |=> flg_q[IAM_F_AL];
	endproperty
	a_arb_mismatch: assert property (p_arb_mismatch)
		else $error("arbitration mismatch did not set flag");

	property p_arb_start;
		(master_mode_i && !format_select && start_det && sda_drive_i)
			|=> bus_status_reg[IAM_SB_AL];
	endproperty
	a_arb_start: assert property (p_arb_start)
		else $error("start while driving high did not set flag");

	property p_overrun;
		(format_select && byte_done && rx_full_flag_o)
			|=> bus_status_reg[2] && $stable(rx_data_o);
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun not flagged or data overwritten");

	property p_al_hold;
		flg_q[IAM_F_AL] && !(wr_stat && arm_q[IAM_F_AL])
			|=> flg_q[IAM_F_AL];
	endproperty
	a_al_hold: assert property (p_al_hold)
		else $error("arbitration flag cleared without read then write");

	property p_own_match;
		(own_hit && !gc_addr) |=> bus_status_reg[1] && addressed_o
			&& !$changed(bus_status_reg[0]);
	endproperty
	a_own_match: assert property (p_own_match)
		else $error("own address match not flagged");

	property p_gen_call;
		gc_hit |=> flg_q[IAM_F_AAS] && flg_q[IAM_F_GC];
	endproperty
	a_gen_call: assert property (p_gen_call)
		else $error("general call not flagged");

	property p_gc_format;
		$rose(flg_q[IAM_F_GC]) |-> !$past(format_select)
			&& !$past(master_mode_i);
	endproperty
	a_gc_format: assert property (p_gc_format)
		else $error("general call flag set outside two-wire slave rx");

	property p_aas_hold;
		flg_q[IAM_F_AAS] && !arm_q[IAM_F_AAS] |=> flg_q[IAM_F_AAS];
	endproperty
	a_aas_hold: assert property (p_aas_hold)
		else $error("address match flag cleared while not armed");

	property p_rx_full;
		rx_take |=> rx_full_flag_o && (rx_data_o == $past(rx_byte));
	endproperty
	a_rx_full: assert property (p_rx_full)
		else $error("received byte not moved or full not set");

endmodule // iam_status_flags

`default_nettype wire

// File: tb/iam_bus_model.sv
/*
 * Behavioural peer on the two-wire link: drives SCL and SDA levels.
 * Assumes pull-ups on both lines, so a released line reads high.
 */
`timescale 1ns/10ps
`default_nettype none

module iam_bus_model (
	// Link lines seen by the device
	output logic scl_o,
	output logic sda_o
);
	// Idle bus: both lines released, the clock stands still between frames.
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	// Start: SDA falls while SCL is high; ends with SCL low.
	task automatic start_c();
		sda_o = 1'b1;
		#40 scl_o = 1'b1;
		#40 sda_o = 1'b0;
		#40 scl_o = 1'b0;
	endtask

	// Stop: SDA rises while SCL is high.
	task automatic stop_c();
		sda_o = 1'b0;
		#40 scl_o = 1'b1;
		#40 sda_o = 1'b1;
		#40;
	endtask

	// Clocks n bits MSB first; bits past the eighth leave SDA released.
	// SCL is pulled low first so that the first bit gets a real rising
	// edge; SCL then rests low after the frame until the next condition.
	task automatic send_byte(input logic [7:0] b, input int n);
		scl_o = 1'b0;
		#20;
		for (int i = 0; i < n; i++) begin
			sda_o = (i < 8) ? b[7-i] : 1'b1;
			#20 scl_o = 1'b1;
			#40 scl_o = 1'b0;
			#20;
		end
		sda_o = 1'b1; // Released after the frame; the pull-up wins.
	endtask
endmodule // iam_bus_model

`default_nettype wire

// File: tb/tb_top.sv
/*
 * Self-checking bench for the address-match and status-flag block.
 * Assumes the design answers on AXI4-Lite as its hand-over describes.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top import iam_pkg::*;;
	logic clk_sys_i, resetn_i, clk_en_i, scl_i, sda_i;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, addressed_o, rx_full_flag_o, irq_o;
	logic master_mode_i, transmit_mode_i, sda_drive_i;
	logic [IAM_AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [7:0]  rx_data_o;
	int          err_count, tests_run;

	iam_bus_model u_bus (.scl_o(scl_i), .sda_o(sda_i));
	iam_status_flags u_dut (.clk_sys_i, .resetn_i, .clk_en_i,
		.s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
		.s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
		.s_axi_rresp, .scl_i, .sda_i, .master_mode_i, .transmit_mode_i,
		.sda_drive_i, .addressed_o, .rx_full_flag_o, .rx_data_o, .irq_o);

	// Free-running clock only; quiet inputs and the enable are set in the main process below.
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// Write: ready is looked at in the low phase, the edge after takes it.
	task automatic wr(logic [7:0] a, logic [31:0] d);
		logic ta, tw, tb;
		@(posedge clk_sys_i);
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_bready  <= 1'b1;
		for (int n = 0; n < 100; n++) begin
			@(negedge clk_sys_i);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bvalid;
			@(posedge clk_sys_i);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) begin
				s_axi_bready <= 1'b0;
				return;
			end
		end
		err_count++;
		end_sim();
	endtask

	// Read: valid and data are looked at in the low phase, where they
	// already hold the values that the next rising edge samples.
	task automatic rdr(logic [7:0] a);
		logic ta, tr;
		@(posedge clk_sys_i);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr  <= a;
		s_axi_rready  <= 1'b1;
		for (int n = 0; n < 100; n++) begin
			@(negedge clk_sys_i);
			ta = s_axi_arvalid & s_axi_arready;
			tr = s_axi_rvalid;
			{rd, rs} = {s_axi_rdata, s_axi_rresp};
			@(posedge clk_sys_i);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) begin
				s_axi_rready <= 1'b0;
				return;
			end
		end
		err_count++;
		end_sim();
	endtask

	// Reads a register and compares the word seen with the one expected.
	task automatic rchk(string nm, logic [7:0] a, logic [31:0] e);
		rdr(a);
		chk(nm, rd, e);
	endtask

	task automatic settle();
		repeat (12) @(posedge clk_sys_i);
	endtask

	// Reset values, then an unmapped offset.
	task automatic t_reset();
		rchk("status", IAM_OFF_STATUS, 32'h0);
		rchk("slvadr", IAM_OFF_SLVADR, 32'h0);
		rchk("rxdata", IAM_OFF_RXDATA, 32'hff);
		rdr(8'h14);
		chk("unmapped", rs, IAM_RESP_SLVERR);
		$display("t_reset done");
	endtask

	// Synchronous format: second byte arrives while the first is unread.
	task automatic t_overrun();
		wr(IAM_OFF_SLVADR, 32'h01);
		u_bus.send_byte(8'h3c, 8);
		settle();
		chk("rxfull", rx_full_flag_o, 1'b1);
		u_bus.send_byte(8'hc5, 8);
		settle();
		chk("rxkeep", rx_data_o, 8'h3c);
		chk("irq_masked", irq_o, 1'b0);
		// Both events are recorded although masked; the read clears them.
		rchk("irq_ovr", IAM_OFF_IRQSTAT, 32'hc);
		wr(IAM_OFF_STATUS, 32'h0);
		rchk("ovr", IAM_OFF_STATUS, 32'h24);
		wr(IAM_OFF_STATUS, 32'h0);
		rchk("ovr_clr", IAM_OFF_STATUS, 32'h0);
		$display("t_overrun done");
	endtask

	// Own address 0x50 in two-wire format, interrupt path enabled.
	task automatic t_addr();
		wr(IAM_OFF_SLVADR, 32'ha0);
		wr(IAM_OFF_IRQMASK, 32'hf);
		u_bus.start_c();
		u_bus.send_byte(8'ha1, 9);
		settle();
		chk("addressed", addressed_o, 1'b1);
		chk("irq", irq_o, 1'b1);
		rchk("aas", IAM_OFF_STATUS, 32'h22);
		rchk("irqstat", IAM_OFF_IRQSTAT, 32'ha);
		chk("irq_clr", irq_o, 1'b0);
		wr(IAM_OFF_STATUS, 32'h0);
		rchk("aas_clr", IAM_OFF_STATUS, 32'h0);
		rchk("rxdata", IAM_OFF_RXDATA, 32'ha1);
		u_bus.stop_c();
		settle();
		chk("released", addressed_o, 1'b0);
		$display("t_addr done");
	endtask

	// General call, then a frame for another slave.
	task automatic t_gcall();
		u_bus.start_c();
		u_bus.send_byte(8'h00, 9);
		settle();
		rchk("gc", IAM_OFF_STATUS, 32'h23);
		wr(IAM_OFF_STATUS, 32'h0);
		rchk("gc_clr", IAM_OFF_STATUS, 32'h0);
		u_bus.start_c();
		u_bus.send_byte(8'h52, 9);
		settle();
		rchk("other", IAM_OFF_STATUS, 32'h0);
		chk("not_addr", addressed_o, 1'b0);
		u_bus.stop_c();
		$display("t_gcall done");
	endtask

	// Master transmit: start with drive high, then a driven-low mismatch.
	task automatic t_arb();
		@(posedge clk_sys_i);
		{master_mode_i, transmit_mode_i, sda_drive_i} <= 3'h7;
		u_bus.start_c();
		settle();
		rchk("al_start", IAM_OFF_STATUS, 32'h04);
		wr(IAM_OFF_STATUS, 32'h0);
		sda_drive_i <= 1'b0;
		u_bus.send_byte(8'h80, 1);
		settle();
		rchk("al_bit", IAM_OFF_STATUS, 32'h04);
		wr(IAM_OFF_STATUS, 32'h0);
		u_bus.stop_c();
		settle();
		rchk("al_clr", IAM_OFF_STATUS, 32'h0);
		$display("t_arb done");
	endtask

	// Quiet inputs from one process only; the enable stays high.
	initial begin
		{resetn_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, master_mode_i} = 3'h0;
		{transmit_mode_i, sda_drive_i} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'h1;
		clk_en_i = 1'b1;
		repeat (6) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		t_reset();
		t_overrun();
		t_addr();
		t_gcall();
		t_arb();
		end_sim();
	end
endmodule // tb_top

`default_nettype wire
